// file: hdl/notch_averaging_filter.sv
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "naf_defines.svh"

// What this block does
// - nulls at notch frequency and its multiples
// - filtering lasts one notch period
// - takes 31250 samples per second, averages blocks
// - sample count is rounded 31250 over notch
// - result time is settle plus filter plus divide plus overhead
// - zero settling parameter selects built-in default
// - bridge mode settles in each of four subs
module notch_averaging_filter (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter sample stream
    input wire logic sampleValid,
    input wire logic signed [23:0] sampleData,
    // result stream
    output logic resultValid,
    output logic signed [31:0] resultData,
    output logic [1:0] resultSub
);
    naf_pkg::naf_state_t stateQ;
    logic [15:0] notchHzQ;
    logic [15:0] settleUsQ;
    logic bridgeQ;
    logic startQ;
    logic doneQ;
    logic [15:0] countQ;
    logic [15:0] takenQ;
    logic signed [39:0] accQ;
    logic [31:0] timerQ;
    logic [31:0] durationQ;
    logic [31:0] elapsedQ;
    logic [1:0] subQ;
    logic signed [31:0] lastResultQ;
    logic divStart;
    logic divDone;
    logic signed [31:0] divQuot;
    logic apbAccess;
    logic apbWrite;
    logic apbRead;
    logic [31:0] readMux;
    logic addrOk;
    logic measEnd;
    logic [31:0] settleTotQ;
    logic [31:0] filterTotQ;
    logic [31:0] otherTotQ;
    logic [15:0] effNotchQ;
    logic [15:0] resultCntQ;

    // rounded divide of the converter rate by the notch frequency
    function automatic logic [15:0] samples_for(input logic [15:0] hz);
        logic [31:0] rate;
        logic [31:0] den;
        rate = 32'(`NAF_SAMPLE_RATE_HZ);
        den = (hz == 16'h0) ? 32'h1 : {16'h0, hz};
        samples_for = 16'((rate + (den >> 1)) / den);
        if (samples_for == 16'h0) begin
            samples_for = 16'h1;
        end
    endfunction

    // settling interval in clock cycles
    function automatic logic [31:0] settle_cycles(input logic [15:0] us);
        if (us == 16'h0) begin
            settle_cycles = 32'(`NAF_DEFAULT_SETTLE_CYCLES);
        end else begin
            settle_cycles = {16'h0, us} * 32'(`NAF_US_CYCLES);
        end
    endfunction

    // true on the final sub-measurement of a run
    function automatic logic is_last_sub(input logic bridge, input logic [1:0] sub);
        is_last_sub = !bridge || sub == 2'(`NAF_BRIDGE_SUBS - 1);
    endfunction

    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    assign apbRead = apbAccess && !pwrite;

    always_comb begin
        addrOk = 1'b1;
        readMux = 32'h0;
        case (paddr)
            `NAF_CTRL_OFF: readMux = {30'h0, bridgeQ, 1'b0};
            `NAF_NOTCH_OFF: readMux = {16'h0, notchHzQ};
            `NAF_SETTLE_OFF: readMux = {16'h0, settleUsQ};
            `NAF_STATUS_OFF: readMux = {28'h0, subQ, doneQ, stateQ != naf_pkg::ST_IDLE};
            `NAF_RESULT_OFF: readMux = lastResultQ;
            `NAF_COUNT_OFF: readMux = {16'h0, countQ};
            `NAF_DURATION_OFF: readMux = durationQ;
            `NAF_SETTLE_TOT_OFF: readMux = settleTotQ;
            `NAF_FILTER_TOT_OFF: readMux = filterTotQ;
            `NAF_OTHER_TOT_OFF: readMux = otherTotQ;
            `NAF_EFF_NOTCH_OFF: readMux = {16'h0, effNotchQ};
            `NAF_RESULTS_OFF: readMux = {16'h0, resultCntQ};
            default: addrOk = 1'b0;
        endcase
    end

    // bus answer: one wait state, pready on the second access cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= apbAccess && !pready;
            pslverr <= apbAccess && !pready && !addrOk;
            // read data only stands in the answer cycle
            prdata <= (apbRead && !pready && addrOk) ? readMux : 32'h0;
        end
    end

    // configuration
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            notchHzQ <= `NAF_NOTCH_RESET;
            settleUsQ <= `NAF_SETTLE_RESET;
            bridgeQ <= 1'b0;
            startQ <= 1'b0;
        end else begin
            startQ <= 1'b0;
            // setup is frozen while a run is busy
            if (apbWrite && pready && stateQ == naf_pkg::ST_IDLE) begin
                case (paddr)
                    `NAF_CTRL_OFF: begin
                        bridgeQ <= pwdata[`NAF_CTRL_BRIDGE_BIT];
                        startQ <= pwdata[`NAF_CTRL_START_BIT];
                    end
                    `NAF_NOTCH_OFF: notchHzQ <= pwdata[15:0];
                    `NAF_SETTLE_OFF: settleUsQ <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // done flag: a finishing measurement wins over a clearing status read
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            doneQ <= 1'b0;
        end else if (measEnd) begin
            doneQ <= 1'b1;
        end else if (apbRead && pready && paddr == `NAF_STATUS_OFF) begin
            doneQ <= 1'b0;
        end
    end

    assign divStart = stateQ == naf_pkg::ST_FILTER && takenQ == countQ;
    assign measEnd = stateQ == naf_pkg::ST_OVERHEAD && timerQ <= 32'h1 &&
        is_last_sub(bridgeQ, subQ);

    // measurement sequence
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stateQ <= naf_pkg::ST_IDLE;
            countQ <= 16'h0;
            takenQ <= 16'h0;
            accQ <= 40'sh0;
            timerQ <= 32'h0;
            subQ <= 2'h0;
        end else begin
            case (stateQ)
                naf_pkg::ST_IDLE: begin
                    if (startQ) begin
                        countQ <= samples_for(notchHzQ);
                        subQ <= 2'h0;
                        timerQ <= settle_cycles(settleUsQ);
                        stateQ <= naf_pkg::ST_SETTLE;
                    end
                end
                naf_pkg::ST_SETTLE: begin
                    timerQ <= timerQ - 32'h1;
                    if (timerQ <= 32'h1) begin
                        // sum starts empty as the window opens
                        accQ <= 40'sh0;
                        takenQ <= 16'h0;
                        stateQ <= naf_pkg::ST_FILTER;
                    end
                end
                naf_pkg::ST_FILTER: begin
                    // window of count samples spans one notch period
                    if (divStart) begin
                        stateQ <= naf_pkg::ST_DIVIDE;
                    end else if (sampleValid) begin
                        accQ <= accQ + 40'(sampleData);
                        takenQ <= takenQ + 16'h1;
                    end
                end
                naf_pkg::ST_DIVIDE: begin
                    if (divDone) begin
                        timerQ <= 32'(`NAF_OVERHEAD_CYCLES);
                        stateQ <= naf_pkg::ST_OVERHEAD;
                    end
                end
                naf_pkg::ST_OVERHEAD: begin
                    timerQ <= timerQ - 32'h1;
                    if (timerQ <= 32'h1) begin
                        if (!is_last_sub(bridgeQ, subQ)) begin
                            subQ <= subQ + 2'h1;
                            timerQ <= settle_cycles(settleUsQ);
                            stateQ <= naf_pkg::ST_SETTLE;
                        end else begin
                            stateQ <= naf_pkg::ST_IDLE;
                        end
                    end
                end
                default: stateQ <= naf_pkg::ST_IDLE;
            endcase
        end
    end

    // duration of the last measurement in clock cycles
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            elapsedQ <= 32'h0;
            durationQ <= 32'h0;
        end else if (stateQ == naf_pkg::ST_IDLE) begin
            elapsedQ <= 32'h0;
        end else begin
            elapsedQ <= elapsedQ + 32'h1;
            if (measEnd) begin
                durationQ <= elapsedQ + 32'h1;
            end
        end
    end

    // cycles spent settling, filtering, and in divide plus overhead together, over the last run
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            settleTotQ <= 32'h0;
            filterTotQ <= 32'h0;
            otherTotQ <= 32'h0;
        end else if (stateQ == naf_pkg::ST_IDLE && startQ) begin
            settleTotQ <= 32'h0;
            filterTotQ <= 32'h0;
            otherTotQ <= 32'h0;
        end else begin
            case (stateQ)
                naf_pkg::ST_SETTLE: settleTotQ <= settleTotQ + 32'h1;
                naf_pkg::ST_FILTER: filterTotQ <= filterTotQ + 32'h1;
                naf_pkg::ST_DIVIDE: otherTotQ <= otherTotQ + 32'h1;
                naf_pkg::ST_OVERHEAD: otherTotQ <= otherTotQ + 32'h1;
                default: ;
            endcase
        end
    end

    // null actually reached with the rounded count
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            effNotchQ <= 16'h0;
        end else if (stateQ == naf_pkg::ST_IDLE && startQ) begin
            effNotchQ <= samples_for(samples_for(notchHzQ));
        end
    end

    // results produced since reset, wraps
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            resultCntQ <= 16'h0;
        end else if (divDone) begin
            resultCntQ <= resultCntQ + 16'h1;
        end
    end

    // boxcar mean gives nulls at rate/count and multiples
    naf_divider uDiv (
        .clock(clock),
        .rst_b(rst_b),
        .start(divStart),
        .dividend(accQ),
        .divisor(countQ),
        .done(divDone),
        .quotient(divQuot)
    );

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            resultValid <= 1'b0;
            resultData <= 32'sh0;
            resultSub <= 2'h0;
            lastResultQ <= 32'sh0;
        end else begin
            resultValid <= divDone;
            if (divDone) begin
                resultData <= divQuot;
                resultSub <= subQ;
                lastResultQ <= divQuot;
            end
        end
    end
endmodule

// file: hdl/naf_defines.svh
`ifndef NAF_DEFINES_SVH
`define NAF_DEFINES_SVH

// register byte offsets
`define NAF_CTRL_OFF 12'h000
`define NAF_NOTCH_OFF 12'h004
`define NAF_SETTLE_OFF 12'h008
`define NAF_STATUS_OFF 12'h00C
`define NAF_RESULT_OFF 12'h010
`define NAF_COUNT_OFF 12'h014
`define NAF_DURATION_OFF 12'h018
`define NAF_SETTLE_TOT_OFF 12'h01C
`define NAF_FILTER_TOT_OFF 12'h020
`define NAF_OTHER_TOT_OFF 12'h024
`define NAF_EFF_NOTCH_OFF 12'h028
`define NAF_RESULTS_OFF 12'h02C

// control and status fields
`define NAF_CTRL_START_BIT 0
`define NAF_CTRL_BRIDGE_BIT 1
`define NAF_STATUS_BUSY_BIT 0
`define NAF_STATUS_DONE_BIT 1
`define NAF_STATUS_SUB_LSB 2

// reset values
`define NAF_NOTCH_RESET 16'h0032
`define NAF_SETTLE_RESET 16'h0000

// timing
`define NAF_SAMPLE_RATE_HZ 31250
`define NAF_CLOCK_HZ 100000000
`define NAF_SETTLE_DEFAULT_US 450
`define NAF_US_CYCLES (`NAF_CLOCK_HZ / 1000000)
`define NAF_DEFAULT_SETTLE_CYCLES (`NAF_SETTLE_DEFAULT_US * `NAF_US_CYCLES)
`define NAF_OVERHEAD_CYCLES 16
`define NAF_BRIDGE_SUBS 4

`endif

// file: hdl/naf_pkg.sv
package naf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_FILTER,
        ST_DIVIDE,
        ST_OVERHEAD
    } naf_state_t;

    typedef logic signed [23:0] naf_sample_t;
endpackage

// file: hdl/naf_divider.sv
`timescale 1ns/1ps
// sequential signed-by-unsigned divider, rounds to nearest
module naf_divider (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // request
    input wire logic start,
    input wire logic signed [39:0] dividend,
    input wire logic [15:0] divisor,
    // answer
    output logic done,
    output logic signed [31:0] quotient
);
    logic [39:0] remQ;
    logic [39:0] magQ;
    logic [39:0] quoQ;
    logic negQ;
    logic [5:0] bitQ;
    logic busyQ;
    logic [39:0] trial;

    always_comb begin
        trial = {remQ[38:0], magQ[39]};
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            remQ <= 40'h0;
            magQ <= 40'h0;
            quoQ <= 40'h0;
            negQ <= 1'b0;
            bitQ <= 6'h0;
            busyQ <= 1'b0;
            done <= 1'b0;
            quotient <= 32'h0;
        end else begin
            done <= 1'b0;
            if (start) begin
                negQ <= dividend[39];
                // add half divisor so the truncating divide rounds
                magQ <= (dividend[39] ? 40'(-dividend) : dividend) + 40'(divisor >> 1);
                remQ <= 40'h0;
                quoQ <= 40'h0;
                bitQ <= 6'h28;
                busyQ <= 1'b1;
            end else if (busyQ) begin
                magQ <= {magQ[38:0], 1'b0};
                if (trial >= {24'h0, divisor}) begin
                    remQ <= trial - {24'h0, divisor};
                    quoQ <= {quoQ[38:0], 1'b1};
                end else begin
                    remQ <= trial;
                    quoQ <= {quoQ[38:0], 1'b0};
                end
                bitQ <= bitQ - 6'h01;
                if (bitQ == 6'h01) begin
                    busyQ <= 1'b0;
                    done <= 1'b1;
                    quotient <= negQ ? 32'(-{quoQ[38:0], trial >= {24'h0, divisor}})
                                     : 32'({quoQ[38:0], trial >= {24'h0, divisor}});
                end
            end
        end
    end
endmodule

// file: sim/naf_sample_src.sv
`timescale 1ns/1ps
module naf_sample_src #(
    parameter int PERIOD = 3200
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // value to emit
    input wire logic signed [23:0] level,
    // sample stream
    output logic sampleValid,
    output logic signed [23:0] sampleData
);
    logic [15:0] tick_q;
    // fixed converter rate, one strobe per period
    always_ff @(posedge clock) begin
        if (!rst_b || tick_q == 16'(PERIOD - 1)) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end
    assign sampleValid = rst_b && tick_q == 16'(PERIOD - 1);
    // inverted value between strobes
    assign sampleData = sampleValid ? level : ~level;
endmodule

// file: sim/naf_chk.sv
`timescale 1ns/1ps
module naf_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // streams
    input wire logic sampleValid,
    input wire logic resultValid,
    input wire logic signed [31:0] resultData,
    input wire logic [1:0] resultSub
);
    logic [7:0] age_q;
    logic [1:0] lastSub_q;
    // cycles since the last sample, saturating
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            age_q <= 8'hFF;
        end else if (sampleValid) begin
            age_q <= 8'h00;
        end else if (age_q != 8'hFF) begin
            age_q <= age_q + 8'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lastSub_q <= 2'h0;
        end else if (resultValid) begin
            lastSub_q <= resultSub;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence apbWait;
        !pready ##1 pready;
    endsequence
    sequence quietGap;
        !resultValid [*8];
    endsequence
    chk_ready_wait: assert property (psel && !penable |=> apbWait)
        else $error("pready not after one wait");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_result_gap: assert property (resultValid |=> quietGap)
        else $error("result too soon after result");
    chk_result_sample: assert property (resultValid |-> age_q < 8'h64)
        else $error("result not tied to a sample");
    chk_data_hold: assert property (!resultValid |-> $stable(resultData))
        else $error("result data changed without strobe");
    chk_sub_step: assert property (resultValid && resultSub != 2'h0 |->
        resultSub == lastSub_q + 2'h1)
        else $error("sub index out of order");
endmodule
bind notch_averaging_filter naf_chk i_naf_chk (.clock, .rst_b, .psel, .penable, .prdata,
    .pready, .pslverr, .sampleValid, .resultValid, .resultData, .resultSub);

// file: sim/tb_notch_averaging_filter.sv
`timescale 1ns/1ps
`include "naf_defines.svh"
module tb_notch_averaging_filter;
    logic clock, rst_b, psel, penable, pwrite, sampleValid, pready, pslverr, resultValid, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [23:0] level, sampleData;
    logic signed [31:0] resultData;
    logic [1:0] resultSub;
    int error_cnt, checked, results;
    notch_averaging_filter i_notch_averaging_filter (.clock, .rst_b, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sampleValid, .sampleData, .resultValid,
        .resultData, .resultSub);
    naf_sample_src i_naf_sample_src (.clock, .rst_b, .level, .sampleValid, .sampleData);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            print_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one measurement: constant input, check mean, sub index, timing, count
    task automatic run(input logic [15:0] notch, input logic [15:0] settle, input logic br,
        input logic signed [31:0] exp, input int n, input int minc);
        int k, s, t, m, st, ft, ot;
        level <= exp[23:0];
        apb(1'b1, `NAF_NOTCH_OFF, {16'h0000, notch});
        apb(1'b1, `NAF_SETTLE_OFF, {16'h0000, settle});
        apb(1'b1, `NAF_CTRL_OFF, {30'h0, br, 1'b1});
        apb(1'b1, `NAF_NOTCH_OFF, 32'h1);
        for (s = 0; s <= 3 * br; s++) begin
            for (k = 0; k < 60000 && resultValid !== 1'b1; k++) @(posedge clock);
            if (k == 60000) begin
                chk(32'h0, 32'h1);
                print_verdict;
            end
            chk(resultData, exp);
            chk(resultSub, s);
            results++;
            chk(k >= minc + (n - 1) * 3200 && k <= minc + (n + 1) * 3200 + 300, 1);
            @(posedge clock);
        end
        repeat (16) @(posedge clock);
        apb(1'b0, `NAF_COUNT_OFF, 32'h0);
        chk(rd, n);
        apb(1'b0, `NAF_NOTCH_OFF, 32'h0);
        chk(rd, notch);
        apb(1'b0, `NAF_STATUS_OFF, 32'h0);
        chk(rd[1], 1'b1);
        t = (settle == 16'h0) ? `NAF_DEFAULT_SETTLE_CYCLES : settle * `NAF_US_CYCLES;
        m = br ? `NAF_BRIDGE_SUBS : 1;
        apb(1'b0, `NAF_RESULT_OFF, 32'h0);
        chk(rd, exp);
        apb(1'b0, `NAF_EFF_NOTCH_OFF, 32'h0);
        chk(rd, (`NAF_SAMPLE_RATE_HZ + n / 2) / n);
        apb(1'b0, `NAF_SETTLE_TOT_OFF, 32'h0);
        chk(rd, m * t);
        st = rd;
        apb(1'b0, `NAF_FILTER_TOT_OFF, 32'h0);
        chk(rd >= m * ((n - 1) * 3200 + 2) && rd <= m * (n * 3200 + 1), 1);
        ft = rd;
        apb(1'b0, `NAF_OTHER_TOT_OFF, 32'h0);
        chk(rd >= m * (`NAF_OVERHEAD_CYCLES + 1) &&
            rd <= m * (`NAF_OVERHEAD_CYCLES + 64), 1);
        ot = rd;
        apb(1'b0, `NAF_DURATION_OFF, 32'h0);
        chk(rd, st + ft + ot);
        apb(1'b0, `NAF_RESULTS_OFF, 32'h0);
        chk(rd, results);
    endtask
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        level = 24'sh0;
        error_cnt = 0;
        checked = 0;
        results = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, `NAF_NOTCH_OFF, 32'h0);
        chk(rd, 32'h32);
        apb(1'b0, `NAF_SETTLE_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        run(16'h7A12, 16'h1, 1'b0, 32'sh123, 1, 100);
        run(16'h2EE0, 16'h1, 1'b0, -32'sh5, 3, 100);
        run(16'h2710, 16'h1, 1'b0, 32'sh7FFFFF, 3, 100);
        run(16'h7A12, 16'h1, 1'b1, 32'sh40, 1, 100);
        run(16'h7A12, 16'h0, 1'b0, -32'sh800000, 1, 45000);
        print_verdict;
    end
endmodule
